/* dv/aspt_checker.sv */
// concurrent checks on the bus and link of the serial port pair
`timescale 1ns/10ps
module aspt_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  input wire logic dev_to_far,
  input wire logic far_to_dev,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic nine_bit_mode
);
  // a start counts only after an idle run longer than any in-frame run
  logic [7:0] high_run;
  logic       dev_start;
  logic       far_take;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      high_run <= 8'h00;
    else if (!dev_to_far)
      high_run <= 8'h00;
    else if (high_run != 8'hC8)
      high_run <= high_run + 8'h01;
  end
  assign dev_start = !dev_to_far && (high_run == 8'hC8);
  assign far_take  = tx_valid && tx_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ack_next;
    wb_cyc && wb_stb && !wb_ack |=> wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("bus request not answered next cycle");
  property p_ack_pulse;
    wb_ack |=> !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack longer than one cycle");
  property p_dev_start;
    dev_start |-> ##8 !dev_to_far;
  endproperty
  a_dev_start: assert property (p_dev_start)
    else $error("port start bit too short");
  property p_dev_stop8;
    dev_start && !nine_bit_mode |-> ##152 dev_to_far;
  endproperty
  a_dev_stop8: assert property (p_dev_stop8)
    else $error("port stop bit missing in ten bit frame");
  property p_dev_stop9;
    dev_start && nine_bit_mode |-> ##168 dev_to_far;
  endproperty
  a_dev_stop9: assert property (p_dev_stop9)
    else $error("port stop bit missing in eleven bit frame");
  property p_dev_heard;
    dev_start && !nine_bit_mode |-> ##[150:162] rx_valid;
  endproperty
  a_dev_heard: assert property (p_dev_heard)
    else $error("remote did not finish port frame in time");
  property p_far_start;
    far_take |=> (!far_to_dev) [*8];
  endproperty
  a_far_start: assert property (p_far_start)
    else $error("remote start bit not driven");
  property p_far_stop;
    far_take && !nine_bit_mode |-> ##153 far_to_dev;
  endproperty
  a_far_stop: assert property (p_far_stop)
    else $error("remote stop bit missing");
  c_dev_frame: cover property (dev_start);
  c_far_frame: cover property (far_take);
  c_heard: cover property (rx_valid);
endmodule : aspt_checker

/* dv/tb_async_serial_port_with_timer_baud.sv */
// bench: port and remote joined over the link, driven through wishbone
`timescale 1ns/10ps
module tb_async_serial_port_with_timer_baud;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0]  wb_sel = 4'h0;
  logic [9:0]  wb_adr = 10'h000;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
  logic        wb_ack, serial_irq, ext_osc = 1'b0, ext_pin = 1'b0;
  logic        nine = 1'b0, tx_ninth = 1'b0, tx_valid = 1'b0;
  logic        tx_ready, rx_ninth, rx_stop, rx_valid;
  logic        rb8 = 1'b0, ri = 1'b0, irq_en = 1'b1;
  logic [7:0]  tx_data = 8'h00, rx_data, cfg = 8'h10, last = 8'h00, q;
  logic [7:0]  modes [3] = '{8'h10, 8'h98, 8'h90};
  logic [31:0] seed = 32'hCA61546B;
  int          bad_count = 0, num_checks = 0;
  aspt_link_if link ();
  aspt_port aspt_port_inst (.clk(clk), .rst_b(rst_b), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_sel(wb_sel), .wb_adr(wb_adr),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack),
    .ext_osc(ext_osc), .baud_timer_ext_input(ext_pin),
    .serial_irq(serial_irq), .link(link.dev));
  // two overflows of (256-0xFE) ticks of clk/4 give 16 clocks per bit
  aspt_remote #(.CLKS_PER_BIT(16)) aspt_remote_inst (.clk(clk),
    .rst_b(rst_b), .nine_bit_mode(nine), .tx_data(tx_data),
    .tx_ninth(tx_ninth), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_ninth(rx_ninth), .rx_stop(rx_stop),
    .rx_valid(rx_valid), .link(link.far));
  aspt_checker aspt_checker_inst (.clk(clk), .rst_b(rst_b),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack),
    .dev_to_far(link.dev_to_far), .far_to_dev(link.far_to_dev),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .nine_bit_mode(nine));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    ext_osc <= ~ext_osc;
    ext_pin <= ext_osc ^ seed[9];
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [7:0] ctl(input logic ti);
    return cfg | 8'h40 | {5'h00, rb8, ti, ri};
  endfunction : ctl
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic wb(input logic we, input logic [7:0] idx,
                    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'h1;
    wb_adr <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    check("ack", wb_ack, 1'b1);
    check("ack delay", n, 2);
  endtask : wb
  task automatic rc(input string nm, input logic [7:0] idx,
                    input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check(nm, q, exp);
  endtask : rc
  // reload 0 makes the count wrap mod 256, so the delta is the tick count;
  // a 480-cycle window holds whole periods of every tick source
  task automatic rate(input logic [7:0] tc, input logic [7:0] ticks);
    logic [7:0] c0, dt;
    wb(1'b1, aspt_pkg::IDX_TIMER_CTRL, tc);
    rc("timer ctrl", aspt_pkg::IDX_TIMER_CTRL, tc);
    wb(1'b0, aspt_pkg::IDX_TIMER_COUNT, 8'h00);
    c0 = q;
    repeat (477) @(posedge clk);
    wb(1'b0, aspt_pkg::IDX_TIMER_COUNT, 8'h00);
    dt = q - c0;
    check("timer ticks", dt, ticks);
  endtask : rate
  // a control write also clears the ninth receive bit
  task automatic clr();
    wb(1'b1, aspt_pkg::IDX_CONTROL, cfg);
    ri = 1'b0;
    rb8 = 1'b0;
    rc("flags clear", aspt_pkg::IDX_CONTROL, ctl(1'b0));
    check("irq low", serial_irq, 1'b0);
  endtask : clr
  task automatic port_send(input logic [7:0] d);
    int k;
    k = 0;
    wb(1'b1, aspt_pkg::IDX_DATA, d);
    do @(posedge clk); while (rx_valid !== 1'b1 && ++k < 400);
    check("far frame", rx_valid, 1'b1);
    check("far data", rx_data, d);
    check("far ninth", rx_ninth, cfg[7] & cfg[3]);
    check("far stop", rx_stop, 1'b1);
    repeat (250) @(posedge clk);
    rc("tx done", aspt_pkg::IDX_CONTROL, ctl(1'b1));
    check("irq tx", serial_irq, irq_en);
    rc("data read", aspt_pkg::IDX_DATA, last);
    clr();
  endtask : port_send
  task automatic far_in(input logic [7:0] d, input logic n9,
                        input logic ok);
    @(posedge clk);
    tx_data <= d;
    tx_ninth <= n9;
    tx_valid <= 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    repeat (200) @(posedge clk);
    if (ok) begin
      rb8 = cfg[7] ? n9 : 1'b1;
      last = d;
      ri = 1'b1;
    end
    rc("rx flags", aspt_pkg::IDX_CONTROL, ctl(1'b0));
    check("irq rx", serial_irq, ri & irq_en);
    rc("rx data", aspt_pkg::IDX_DATA, last);
  endtask : far_in
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rc("ctl reset", aspt_pkg::IDX_CONTROL, aspt_pkg::CONTROL_RESET);
    rc("reload reset", aspt_pkg::IDX_RELOAD, aspt_pkg::RELOAD_RESET);
    rc("data reset", aspt_pkg::IDX_DATA, 8'h00);
    wb(1'b1, 8'hA0, 8'hFF);
    rc("unmapped", 8'hA0, 8'h00);
    wb(1'b1, aspt_pkg::IDX_CONTROL, 8'h00);
    rc("unused bit", aspt_pkg::IDX_CONTROL, 8'h40);
    rate(8'h00, 8'h00); // stopped
    rate(8'h01, 8'h78); // clk/4
    rate(8'h05, 8'h28); // clk/12
    rate(8'h09, 8'h0A); // clk/48
    rate(8'h0D, 8'h1E); // osc/8, osc toggles every clock
    rate(8'h11, 8'hF0); // pin toggles every clock
    wb(1'b1, aspt_pkg::IDX_RELOAD, 8'hFE);
    wb(1'b1, aspt_pkg::IDX_TIMER_CTRL, 8'h03);
    // the count may need up to 256 ticks before the first reload
    repeat (1100) @(posedge clk);
    foreach (modes[m]) begin
      cfg = modes[m];
      nine <= cfg[7];
      wb(1'b1, aspt_pkg::IDX_CONTROL, cfg);
      for (int i = 0; i < 3; i++) begin
        seed = xs(seed);
        port_send(i == 0 ? 8'h00 : (i == 1 ? 8'hFF : seed[7:0]));
        far_in(seed[15:8], seed[16], 1'b1);
        clr();
      end
    end
    far_in(8'hA5, 1'b1, 1'b1);
    far_in(8'h5A, 1'b0, 1'b0);
    clr();
    cfg = 8'hB0;
    wb(1'b1, aspt_pkg::IDX_CONTROL, cfg);
    far_in(8'h3C, 1'b0, 1'b0);
    far_in(8'hC3, 1'b1, 1'b1);
    clr();
    cfg = 8'h30;
    nine <= 1'b0;
    wb(1'b1, aspt_pkg::IDX_CONTROL, cfg);
    far_in(8'h81, 1'b0, 1'b1);
    clr();
    // an eleven bit frame puts a low ninth bit where the stop is checked
    nine <= 1'b1;
    far_in(8'h18, 1'b0, 1'b0);
    nine <= 1'b0;
    cfg = 8'h00;
    wb(1'b1, aspt_pkg::IDX_CONTROL, cfg);
    far_in(8'h7E, 1'b0, 1'b0);
    cfg = 8'h10;
    irq_en = 1'b0;
    wb(1'b1, aspt_pkg::IDX_TIMER_CTRL, 8'h01);
    wb(1'b1, aspt_pkg::IDX_CONTROL, cfg);
    far_in(8'h42, 1'b0, 1'b1);
    clr();
    conclude();
  end
  initial begin
    #(40 * 30000);
    bad_count++;
    conclude();
  end
endmodule : tb_async_serial_port_with_timer_baud

/* rtl/aspt_link_if.sv */
// serial link between the port and the remote device
`timescale 1ns/10ps
interface aspt_link_if;
  logic dev_to_far;
  logic far_to_dev;
  modport dev (output dev_to_far, input far_to_dev);
  modport far (input dev_to_far, output far_to_dev);
endinterface : aspt_link_if

/* rtl/aspt_pkg.sv */
// constants shared by both ends of the serial port
package aspt_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL     = 8'h98;
  localparam logic [7:0] IDX_DATA        = 8'h99;
  localparam logic [7:0] IDX_RELOAD      = 8'h9A;
  localparam logic [7:0] IDX_TIMER_CTRL  = 8'h9B;
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h9C;
  localparam logic [7:0] CONTROL_RESET   = 8'h40;
  localparam logic [7:0] RELOAD_RESET    = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;
  // control register bits
  localparam int BIT_MODE       = 7;
  localparam int BIT_ONE        = 6;
  localparam int BIT_ADDR_CHECK = 5;
  localparam int BIT_RX_EN      = 4;
  localparam int BIT_TB8        = 3;
  localparam int BIT_RB8        = 2;
  localparam int BIT_TI         = 1;
  localparam int BIT_RI         = 0;
  // timer control bits
  localparam int TC_RUN     = 0;
  localparam int TC_IRQ_EN  = 1;
  localparam int TC_SEL_LSB = 2;
  localparam int TC_SEL_MSB = 4;
  // baud timer clock sources
  localparam logic [2:0] CS_DIV4    = 3'h0;
  localparam logic [2:0] CS_DIV12   = 3'h1;
  localparam logic [2:0] CS_DIV48   = 3'h2;
  localparam logic [2:0] CS_EXT_OSC = 3'h3;
  localparam logic [2:0] CS_EXT_PIN = 3'h4;
  localparam logic [5:0] PRESC_TOP  = 6'h2F;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [2:0] OSC8_LAST  = 3'h7;
  localparam logic [7:0] TIMER_TOP  = 8'hFF;
  // frame lengths in bit times, start and stop included
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
endpackage : aspt_pkg

/* rtl/aspt_port.sv */
// serial port with timer baud generation and wishbone registers
`timescale 1ns/10ps
// Functional notes
// - data writes go transmit, reads return receive
// - completed byte held in receive latch
// - done flags cleared only by software write
// - bit clock is timer overflow halved
// - hidden receive timer shares reload value
// - start edge forces receive timer reload
// - software sets timer overflow at twice baud
// - timer clock from div 4/12/48, osc/8, pin
// - control bit 7 selects 8 or 9 bits
// - 8-bit frame: start, 8 data LSB first, stop
// - 8-bit mode stores stop bit as ninth
// - data write starts send; done at stop
// - receive only while control bit 4 set
// - 8-bit load needs flag clear; filter checks stop
// - overrun keeps first byte, drops later frames
// - 9-bit frame carries ninth bit from bit 3
// - 9-bit stores ninth bit, filter needs it set
// - interrupt request when either done flag set; code also needs timer control bit 1 (irq enable) set
// - receive flag set at stop sample time
// - control bit 6 reads one, ignores writes
// - control at index 98h, resets to 40h
// - master sends addresses ninth one, data zero
// - data write loads transmit shifter, read latch
module aspt_port (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [9:0]  wb_adr,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack,
  input  wire logic        ext_osc,
  input  wire logic        baud_timer_ext_input,
  output logic             serial_irq,
  aspt_link_if.dev         link
);
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BITS = 2'b10} aspt_rx_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} aspt_tx_t;

  logic       frame_mode_select;
  logic       address_filter_check_enable;
  logic       receive_enable_bit;
  logic       ninth_transmit_bit;
  logic       ninth_receive_bit;
  logic       transmit_done_flag;
  logic       receive_done_flag;
  logic [7:0] baud_reload_value;
  logic [7:0] baud_timer_count;
  logic [7:0] rx_timer_count;
  logic [7:0] receive_latch;
  logic       timer_run;
  logic       irq_en;
  logic [2:0] clk_sel;
  logic [5:0] presc;
  logic [2:0] osc_cnt;
  logic       osc_prev;
  logic       pin_prev;
  logic       tx_half;
  logic       rx_half;
  logic       rx_prev;
  aspt_rx_t   rx_state;
  aspt_tx_t   tx_state;
  logic [3:0] rx_cnt;
  logic [7:0] rx_shift;
  logic       rx_ninth;
  logic [3:0] tx_cnt;
  logic [3:0] tx_frame;
  logic [10:0] tx_shift;
  logic       tx_line;

  wire       access = wb_cyc & wb_stb;
  wire [7:0] idx    = wb_adr[9:2];
  wire       wr     = access & wb_ack & wb_we & wb_sel[0];
  wire       wr_ctl = wr & (idx == aspt_pkg::IDX_CONTROL);
  wire       wr_dat = wr & (idx == aspt_pkg::IDX_DATA);
  wire [7:0] wdat   = wb_dat_i[7:0];

  function automatic logic [7:0] ctl_value(input logic m, input logic a,
      input logic r, input logic t8, input logic r8, input logic ti,
      input logic ri);
    ctl_value = {m, 1'b1, a, r, t8, r8, ti, ri};
  endfunction : ctl_value

  function automatic logic [3:0] frame_bits(input logic nine);
    frame_bits = nine ? aspt_pkg::FRAME_BITS_9 : aspt_pkg::FRAME_BITS_8;
  endfunction : frame_bits

  // ack one cycle after the request; write commits at the acked edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wb_ack <= 1'b0;
    else wb_ack <= access & ~wb_ack;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access & ~wb_ack) begin
      case (idx)
        aspt_pkg::IDX_CONTROL: wb_dat_o <= {24'h00_0000, ctl_value(
            frame_mode_select, address_filter_check_enable,
            receive_enable_bit, ninth_transmit_bit, ninth_receive_bit,
            transmit_done_flag, receive_done_flag)};
        aspt_pkg::IDX_DATA: wb_dat_o <= {24'h00_0000, receive_latch};
        aspt_pkg::IDX_RELOAD: wb_dat_o <= {24'h00_0000, baud_reload_value};
        aspt_pkg::IDX_TIMER_CTRL:
          wb_dat_o <= {27'h000_0000, clk_sel, irq_en, timer_run};
        aspt_pkg::IDX_TIMER_COUNT:
          wb_dat_o <= {24'h00_0000, baud_timer_count};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // software-owned control bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_mode_select           <= aspt_pkg::CONTROL_RESET[aspt_pkg::BIT_MODE];
      address_filter_check_enable <= aspt_pkg::CONTROL_RESET[aspt_pkg::BIT_ADDR_CHECK];
      receive_enable_bit          <= aspt_pkg::CONTROL_RESET[aspt_pkg::BIT_RX_EN];
      ninth_transmit_bit          <= aspt_pkg::CONTROL_RESET[aspt_pkg::BIT_TB8];
    end else if (wr_ctl) begin
      frame_mode_select           <= wdat[aspt_pkg::BIT_MODE];
      address_filter_check_enable <= wdat[aspt_pkg::BIT_ADDR_CHECK];
      receive_enable_bit          <= wdat[aspt_pkg::BIT_RX_EN];
      ninth_transmit_bit          <= wdat[aspt_pkg::BIT_TB8];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_reload_value <= aspt_pkg::RELOAD_RESET;
      timer_run         <= aspt_pkg::TIMER_CTRL_RESET[aspt_pkg::TC_RUN];
      irq_en            <= aspt_pkg::TIMER_CTRL_RESET[aspt_pkg::TC_IRQ_EN];
      clk_sel <= aspt_pkg::TIMER_CTRL_RESET[aspt_pkg::TC_SEL_MSB:
                                            aspt_pkg::TC_SEL_LSB];
    end else if (wr) begin
      if (idx == aspt_pkg::IDX_RELOAD) baud_reload_value <= wdat;
      if (idx == aspt_pkg::IDX_TIMER_CTRL) begin
        timer_run <= wdat[aspt_pkg::TC_RUN];
        irq_en    <= wdat[aspt_pkg::TC_IRQ_EN];
        clk_sel   <= wdat[aspt_pkg::TC_SEL_MSB:aspt_pkg::TC_SEL_LSB];
      end
    end
  end

  // timer clock sources; one counter mod 48 serves all system dividers
  wire osc_rise = ext_osc & ~osc_prev;
  wire pin_rise = baud_timer_ext_input & ~pin_prev;
  logic src_tick;
  always_comb begin
    case (clk_sel)
      aspt_pkg::CS_DIV4:    src_tick = (presc[1:0] == aspt_pkg::DIV4_LAST);
      aspt_pkg::CS_DIV12:   src_tick = (presc % 6'd12 ==
                                        {2'b00, aspt_pkg::DIV12_LAST});
      aspt_pkg::CS_DIV48:   src_tick = (presc == aspt_pkg::PRESC_TOP);
      aspt_pkg::CS_EXT_OSC: src_tick = osc_rise &
                                       (osc_cnt == aspt_pkg::OSC8_LAST);
      aspt_pkg::CS_EXT_PIN: src_tick = pin_rise;
      default:              src_tick = 1'b0;
    endcase
  end
  wire tick = timer_run & src_tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      presc    <= 6'h00;
      osc_cnt  <= 3'h0;
      osc_prev <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      presc    <= (presc == aspt_pkg::PRESC_TOP) ? 6'h00 : presc + 6'h01;
      osc_prev <= ext_osc;
      pin_prev <= baud_timer_ext_input;
      if (osc_rise) osc_cnt <= osc_cnt + 3'h1;
    end
  end

  // transmit timer and hidden receive copy, both auto-reloading
  wire tx_ovf      = tick & (baud_timer_count == aspt_pkg::TIMER_TOP);
  wire tx_bit_tick = tx_ovf & tx_half;
  wire rx_live     = (rx_state == RX_IDLE) & receive_enable_bit;
  wire start_det   = rx_live & rx_prev & ~link.far_to_dev;
  wire rx_ovf      = tick & (rx_timer_count == aspt_pkg::TIMER_TOP) &
                     ~start_det;
  wire rx_sample   = rx_ovf & ~rx_half & (rx_state == RX_BITS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_timer_count <= 8'h00;
      tx_half          <= 1'b0;
    end else if (tick) begin
      baud_timer_count <= tx_ovf ? baud_reload_value
                                 : baud_timer_count + 8'h01;
      if (tx_ovf) tx_half <= ~tx_half;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_timer_count <= 8'h00;
      rx_half        <= 1'b0;
    end else if (start_det) begin
      rx_timer_count <= baud_reload_value;
      rx_half        <= 1'b0;
    end else if (tick) begin
      rx_timer_count <= rx_ovf ? baud_reload_value
                               : rx_timer_count + 8'h01;
      if (rx_ovf) rx_half <= ~rx_half;
    end
  end

  // receiver; first overflow after the reload lands mid start bit
  wire [3:0] rx_last  = frame_bits(frame_mode_select) - 4'h1;
  wire       rx_bit   = link.far_to_dev;
  wire       rx_check = frame_mode_select ? rx_ninth : rx_bit;
  wire       rx_end   = rx_sample & (rx_cnt == rx_last);
  wire       rx_load  = rx_end & ~receive_done_flag &
                        (~address_filter_check_enable | rx_check);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= RX_IDLE;
      rx_prev  <= 1'b1;
      rx_cnt   <= 4'h0;
      rx_shift <= 8'h00;
      rx_ninth <= 1'b0;
    end else begin
      rx_prev <= link.far_to_dev;
      case (rx_state)
        RX_IDLE: if (start_det) begin
          rx_state <= RX_BITS;
          rx_cnt   <= 4'h0;
        end
        RX_BITS: if (!receive_enable_bit) begin
          rx_state <= RX_IDLE;
        end else if (rx_sample) begin
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == 4'h0 && rx_bit) rx_state <= RX_IDLE;
          else if (rx_cnt <= 4'h8 && rx_cnt != 4'h0)
            rx_shift <= {rx_bit, rx_shift[7:1]};
          else if (rx_cnt == 4'h9 && frame_mode_select)
            rx_ninth <= rx_bit;
          if (rx_cnt == rx_last) rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      receive_latch     <= 8'h00;
      ninth_receive_bit <= aspt_pkg::CONTROL_RESET[aspt_pkg::BIT_RB8];
    end else if (rx_load) begin
      receive_latch     <= rx_shift;
      ninth_receive_bit <= rx_check;
    end else if (wr_ctl) begin
      ninth_receive_bit <= wdat[aspt_pkg::BIT_RB8];
    end
  end

  // transmitter; a data write while busy is dropped
  wire tx_start = wr_dat & (tx_state == TX_IDLE);
  wire ti_set   = tx_bit_tick & (tx_state == TX_SEND) &
                  (tx_cnt == tx_frame - 4'h1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= TX_IDLE;
      tx_shift <= 11'h7FF;
      tx_cnt   <= 4'h0;
      tx_frame <= aspt_pkg::FRAME_BITS_8;
      tx_line  <= 1'b1;
    end else begin
      case (tx_state)
        TX_IDLE: if (tx_start) begin
          tx_state <= TX_SEND;
          tx_frame <= frame_bits(frame_mode_select);
          tx_cnt   <= 4'h0;
          tx_shift <= frame_mode_select ?
                      {1'b1, ninth_transmit_bit, wdat, 1'b0} :
                      {2'b11, wdat, 1'b0};
        end
        TX_SEND: if (tx_bit_tick) begin
          // one extra bit time keeps the stop bit whole
          if (tx_cnt == tx_frame) begin
            tx_state <= TX_IDLE;
          end else begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_cnt   <= tx_cnt + 4'h1;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
  assign link.dev_to_far = tx_line;

  // done flags: hardware set beats a same-cycle software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      transmit_done_flag <= aspt_pkg::CONTROL_RESET[aspt_pkg::BIT_TI];
      receive_done_flag  <= aspt_pkg::CONTROL_RESET[aspt_pkg::BIT_RI];
    end else begin
      if (ti_set) transmit_done_flag <= 1'b1;
      else if (wr_ctl) transmit_done_flag <= wdat[aspt_pkg::BIT_TI];
      if (rx_load) receive_done_flag <= 1'b1;
      else if (wr_ctl) receive_done_flag <= wdat[aspt_pkg::BIT_RI];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) serial_irq <= 1'b0;
    else serial_irq <= irq_en &
                       (transmit_done_flag | receive_done_flag);
  end
endmodule : aspt_port

/* rtl/aspt_remote.sv */
// remote serial device: fixed-rate frame sender and receiver
`timescale 1ns/10ps
module aspt_remote #(
  parameter int CLKS_PER_BIT = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       nine_bit_mode,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_ninth,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_ninth,
  output logic            rx_stop,
  output logic            rx_valid,
  aspt_link_if.far        link
);
  typedef enum logic [1:0] {RM_IDLE = 2'b01, RM_BUSY = 2'b10} aspt_rm_t;
  localparam logic [15:0] BIT_LAST  = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF_LAST = 16'(CLKS_PER_BIT / 2 - 1);

  if (CLKS_PER_BIT < 4 || CLKS_PER_BIT > 65535) begin : g_chk
    $error("CLKS_PER_BIT out of range");
  end

  aspt_rm_t    tx_state;
  aspt_rm_t    rx_state;
  logic [15:0] tx_div;
  logic [15:0] rx_div;
  logic [3:0]  tx_cnt;
  logic [3:0]  rx_cnt;
  logic [3:0]  frame;
  logic [10:0] tx_shift;
  logic [8:0]  rx_shift;
  logic        rx_prev;

  assign frame    = nine_bit_mode ? aspt_pkg::FRAME_BITS_9
                                  : aspt_pkg::FRAME_BITS_8;
  assign tx_ready = (tx_state == RM_IDLE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= RM_IDLE;
      tx_div   <= 16'h0000;
      tx_cnt   <= 4'h0;
      tx_shift <= 11'h7FF;
    end else begin
      case (tx_state)
        RM_IDLE: if (tx_valid) begin
          tx_state <= RM_BUSY;
          tx_div   <= 16'h0000;
          tx_cnt   <= 4'h0;
          // addresses carry ninth one, data ninth zero
          tx_shift <= nine_bit_mode ? {1'b1, tx_ninth, tx_data, 1'b0}
                                    : {2'b11, tx_data, 1'b0};
        end
        RM_BUSY: if (tx_div == BIT_LAST) begin
          tx_div   <= 16'h0000;
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_cnt   <= tx_cnt + 4'h1;
          if (tx_cnt == frame - 4'h1) tx_state <= RM_IDLE;
        end else begin
          tx_div <= tx_div + 16'h0001;
        end
        default: tx_state <= RM_IDLE;
      endcase
    end
  end
  assign link.far_to_dev = tx_shift[0];

  // receiver samples mid-bit, timed from the falling start edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= RM_IDLE;
      rx_prev  <= 1'b1;
      rx_div   <= 16'h0000;
      rx_cnt   <= 4'h0;
      rx_shift <= 9'h000;
      rx_data  <= 8'h00;
      rx_ninth <= 1'b0;
      rx_stop  <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_prev  <= link.dev_to_far;
      rx_valid <= 1'b0;
      case (rx_state)
        RM_IDLE: if (rx_prev && !link.dev_to_far) begin
          rx_state <= RM_BUSY;
          rx_div   <= BIT_LAST - HALF_LAST;
          rx_cnt   <= 4'h0;
        end
        RM_BUSY: if (rx_div == BIT_LAST) begin
          rx_div <= 16'h0000;
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == 4'h0 && link.dev_to_far) begin
            rx_state <= RM_IDLE;
          end else if (rx_cnt == frame - 4'h1) begin
            rx_state <= RM_IDLE;
            rx_data  <= rx_shift[8:1];
            rx_ninth <= nine_bit_mode ? rx_shift[0] : 1'b0;
            rx_stop  <= link.dev_to_far;
            rx_valid <= 1'b1;
          end else if (rx_cnt != 4'h0) begin
            if (rx_cnt <= 4'h8) rx_shift <= {link.dev_to_far, rx_shift[8:1]};
            else rx_shift <= {rx_shift[8:1], link.dev_to_far};
          end
        end else begin
          rx_div <= rx_div + 16'h0001;
        end
        default: rx_state <= RM_IDLE;
      endcase
    end
  end
endmodule : aspt_remote
